// ### verilog/mrs_pkg.sv
// shared constants, types and the frame check function of the request handler
package mrs_pkg;

  localparam int CLK_NS = 20;
  // end-of-frame silence: 3.5 characters, 2 ms at 19200 baud
  localparam int SILENCE_NS = 2000000;
  localparam int SILENCE_CYCLES = SILENCE_NS / CLK_NS;
  localparam int SIL_W = 20;

  localparam int FRAME_MAX = 256;
  localparam int HDR_BYTES = 11;

  localparam logic [15:0] MAX_READ_REGS = 16'h007D;
  localparam logic [15:0] MAX_WRITE_REGS = 16'h007B;

  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] FC_RDWR = 8'h17;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h02;

  localparam logic [7:0] NODE_BCAST = 8'h00;
  localparam logic [7:0] NODE_MAX = 8'hF7;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  localparam logic [8:0] LEN_MIN = 9'h004;
  localparam logic [8:0] LEN_SHORT = 9'h008;
  localparam logic [8:0] LEN_WN_HDR = 9'h009;
  localparam logic [8:0] LEN_RW_HDR = 9'h00D;
  localparam logic [7:0] DATA_AT_WN = 8'h07;
  localparam logic [7:0] DATA_AT_RW = 8'h0B;
  localparam logic [8:0] BODY_EXC = 9'h003;
  localparam logic [8:0] BODY_ECHO = 9'h006;
  localparam logic [8:0] BODY_READ = 9'h003;

  typedef enum logic [3:0] {
    S_RX = 4'h0,
    S_CHECK = 4'h1,
    S_WR1 = 4'h2,
    S_WA = 4'h3,
    S_WB = 4'h4,
    S_WC = 4'h5,
    S_RESP = 4'h6,
    S_TX = 4'h7,
    S_FETCH = 4'h8,
    S_FWAIT = 4'h9
  } mrs_state_t;

  typedef enum logic [1:0] {
    K_EXC = 2'b00,
    K_ECHO = 2'b01,
    K_READ = 2'b10
  } mrs_kind_t;

  // first eleven request bytes, byte 0 in the top bits
  typedef struct packed {
    logic [7:0] node;
    logic [7:0] func;
    logic [15:0] start_a;
    logic [15:0] count_a;
    logic [15:0] start_b;
    logic [15:0] count_b;
    logic [7:0] wbytes;
  } mrs_req_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mrs_reg_req_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

endpackage : mrs_pkg

// ### verilog/mrs_frame_mem.sv
// request frame buffer, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module mrs_frame_mem (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:mrs_pkg::FRAME_MAX-1];

  // no reset: contents are only read after being written by the same frame
  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule : mrs_frame_mem
`default_nettype wire

// ### verilog/mrs_func_handler.sv
// request decoder and response builder of the serial register slave
// What this block does
// - multi-byte fields travel most significant byte first
// - frame check value goes low byte first, high byte last
// - exception responses set bit 7 of the function code
// - accept function codes 3, 6, 16 and 23
// - byte 0 is target node; 1 to 247 unicast, 0 for everyone
// - read count above limit answers exception code 2
// - read response: node, function, byte count, data, check at 3+count
// - response byte 0 is always the own node address
// - write-single: write the register first, then echo the request
// - write-single carries and applies only 16 data bits
// - write-multiple response: node, function, start, count, check
// - write requests above limit are dropped without answer
// - read/write writes one array and reads another in one go
// - silence of 3.5 characters ends a frame; bad check drops it
// - broadcast requests execute but never answer
// - 8 data bits per character; always send two stop bits
`timescale 1ns/1ps
`default_nettype none
module mrs_func_handler #(
  parameter int SILENCE_CYCLES = mrs_pkg::SILENCE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] own_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic tx_two_stop,
  output var mrs_pkg::mrs_reg_req_t reg_req,
  input wire logic [15:0] reg_rd_data
);

  localparam int HB = mrs_pkg::HDR_BYTES;

  mrs_pkg::mrs_state_t state, next_state;
  mrs_pkg::mrs_kind_t kind, next_kind;
  mrs_pkg::mrs_req_t req;
  mrs_pkg::mrs_reg_req_t next_reg_req;

  logic [8:0] len, next_len;
  logic [mrs_pkg::SIL_W-1:0] sil, next_sil;
  logic ovf, next_ovf;
  logic [15:0] rx_crc, next_rx_crc;
  logic [8*HB-1:0] hdr, next_hdr;
  logic mem_we;
  logic [7:0] mem_raddr, mem_rdata;
  logic frame_end, rx_restart, frame_ok, rd_bad;

  logic [7:0] exc, next_exc, wptr, next_wptr, wcnt, next_wcnt, whi, next_whi;
  logic [15:0] waddr, next_waddr, rd_addr, next_rd_addr, word, next_word;
  logic [15:0] tx_crc, next_tx_crc;
  logic [8:0] idx, next_idx, nbody;
  logic have_word, next_have_word, wrote, next_wrote;
  logic next_tx_valid;
  logic [7:0] next_tx_data, body_byte, bcount;
  logic need_fetch, data_pos;

  assign req = mrs_pkg::mrs_req_t'(hdr);
  assign tx_two_stop = 1'b1;

  function automatic logic [7:0] hdr_at(input logic [8*HB-1:0] h, input logic [8:0] k);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < HB; i++) begin
      if (k == 9'(i)) begin
        b = h[8*(HB-1-i) +: 8];
      end
    end
    return b;
  endfunction : hdr_at

  // count zero, over limit, or byte count and length disagreeing: drop silently
  function automatic logic wr_bad(input logic [15:0] cnt, input logic [7:0] nbytes,
                                  input logic [8:0] flen, input logic [8:0] base);
    return (cnt == 16'h0000) || (cnt > mrs_pkg::MAX_WRITE_REGS) ||
           (nbytes != {cnt[6:0], 1'b0}) || (flen != base + {1'b0, nbytes});
  endfunction : wr_bad

  mrs_frame_mem u_mem (
    .core_clk(core_clk),
    .ce(ce),
    .we(mem_we),
    .waddr(len[7:0]),
    .wdata(rx_data),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ---- receive side
  assign frame_end = (state == mrs_pkg::S_RX) && !rx_valid && (len != 9'h000) &&
                     (sil == mrs_pkg::SIL_W'(SILENCE_CYCLES - 1));
  assign rx_restart = (state != mrs_pkg::S_RX) && (next_state == mrs_pkg::S_RX);

  always_comb begin
    next_len = len;
    next_sil = sil;
    next_ovf = ovf;
    next_rx_crc = rx_crc;
    next_hdr = hdr;
    mem_we = 1'b0;
    if (rx_restart) begin
      next_len = 9'h000;
      next_sil = '0;
      next_ovf = 1'b0;
      next_rx_crc = mrs_pkg::CRC_INIT;
    end else if (state == mrs_pkg::S_RX) begin
      if (rx_valid) begin
        next_sil = '0;
        if (len == 9'(mrs_pkg::FRAME_MAX)) begin
          next_ovf = 1'b1;
        end else begin
          mem_we = 1'b1;
          next_len = len + 9'h001;
          next_rx_crc = mrs_pkg::crc_byte(rx_crc, rx_data);
          for (int i = 0; i < HB; i++) begin
            if (len == 9'(i)) begin
              next_hdr[8*(HB-1-i) +: 8] = rx_data;
            end
          end
        end
      end else if ((len != 9'h000) && !frame_end) begin
        next_sil = sil + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      len <= 9'h000;
      sil <= '0;
      ovf <= 1'b0;
      rx_crc <= mrs_pkg::CRC_INIT;
      hdr <= '0;
    end else if (ce) begin
      len <= next_len;
      sil <= next_sil;
      ovf <= next_ovf;
      rx_crc <= next_rx_crc;
      hdr <= next_hdr;
    end
  end

  // ---- decode, execute and answer
  // a residue of zero over the whole frame, check bytes included, means a good check
  assign frame_ok = (len >= mrs_pkg::LEN_MIN) && !ovf && (rx_crc == 16'h0000) &&
                    ((req.node == mrs_pkg::NODE_BCAST) || ((req.node == own_addr) &&
                     (own_addr != mrs_pkg::NODE_BCAST) && (own_addr <= mrs_pkg::NODE_MAX)));
  assign rd_bad = (req.count_a == 16'h0000) || (req.count_a > mrs_pkg::MAX_READ_REGS);
  assign bcount = {req.count_a[6:0], 1'b0};
  assign nbody = (kind == mrs_pkg::K_EXC) ? mrs_pkg::BODY_EXC :
                 (kind == mrs_pkg::K_ECHO) ? mrs_pkg::BODY_ECHO :
                 mrs_pkg::BODY_READ + {1'b0, bcount};
  assign data_pos = (kind == mrs_pkg::K_READ) && (idx >= mrs_pkg::BODY_READ) && (idx < nbody);
  assign need_fetch = data_pos && idx[0] && !have_word;

  always_comb begin
    if (idx == 9'h000) begin
      body_byte = own_addr;
    end else if (kind == mrs_pkg::K_EXC) begin
      body_byte = (idx == 9'h001) ? (req.func | mrs_pkg::EXC_FLAG) : exc;
    end else if (kind == mrs_pkg::K_ECHO) begin
      body_byte = hdr_at(hdr, idx);
    end else if (idx == 9'h001) begin
      body_byte = req.func;
    end else if (idx == 9'h002) begin
      body_byte = bcount;
    end else begin
      body_byte = idx[0] ? word[15:8] : word[7:0];
    end
  end

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_exc = exc;
    next_wptr = wptr;
    next_wcnt = wcnt;
    next_whi = whi;
    next_waddr = waddr;
    next_rd_addr = rd_addr;
    next_word = word;
    next_tx_crc = tx_crc;
    next_idx = idx;
    next_have_word = have_word;
    next_wrote = wrote;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_reg_req = '0;
    mem_raddr = wptr;
    case (state)
      mrs_pkg::S_RX: begin
        next_wrote = 1'b0;
        if (frame_end) begin
          next_state = mrs_pkg::S_CHECK;
        end
      end
      mrs_pkg::S_CHECK: begin
        next_kind = mrs_pkg::K_EXC;
        next_exc = mrs_pkg::EXC_BAD_FUNC;
        next_state = mrs_pkg::S_RESP;
        next_rd_addr = req.start_a;
        next_wptr = mrs_pkg::DATA_AT_WN;
        next_wcnt = req.count_a[7:0];
        next_waddr = req.start_a;
        if (!frame_ok) begin
          next_state = mrs_pkg::S_RX;
        end else if (req.func == mrs_pkg::FC_READ) begin
          if (len != mrs_pkg::LEN_SHORT) begin
            next_state = mrs_pkg::S_RX;
          end else if (rd_bad) begin
            next_exc = mrs_pkg::EXC_BAD_VALUE;
          end else begin
            next_kind = mrs_pkg::K_READ;
          end
        end else if (req.func == mrs_pkg::FC_WRITE1) begin
          if (len != mrs_pkg::LEN_SHORT) begin
            next_state = mrs_pkg::S_RX;
          end else begin
            next_kind = mrs_pkg::K_ECHO;
            next_state = mrs_pkg::S_WR1;
          end
        end else if (req.func == mrs_pkg::FC_WRITEN) begin
          if (wr_bad(req.count_a, req.start_b[15:8], len, mrs_pkg::LEN_WN_HDR)) begin
            next_state = mrs_pkg::S_RX;
          end else begin
            next_kind = mrs_pkg::K_ECHO;
            next_state = mrs_pkg::S_WA;
          end
        end else if (req.func == mrs_pkg::FC_RDWR) begin
          if (wr_bad(req.count_b, req.wbytes, len, mrs_pkg::LEN_RW_HDR)) begin
            next_state = mrs_pkg::S_RX;
          end else if (rd_bad) begin
            next_exc = mrs_pkg::EXC_BAD_VALUE;
          end else begin
            next_kind = mrs_pkg::K_READ;
            next_state = mrs_pkg::S_WA;
            next_wptr = mrs_pkg::DATA_AT_RW;
            next_wcnt = req.count_b[7:0];
            next_waddr = req.start_b;
          end
        end
      end
      mrs_pkg::S_WR1: begin
        next_reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: req.start_a,
                         wdata: req.count_a};
        next_wrote = 1'b1;
        next_state = mrs_pkg::S_RESP;
      end
      mrs_pkg::S_WA: begin
        next_state = mrs_pkg::S_WB;
      end
      mrs_pkg::S_WB: begin
        mem_raddr = wptr + 8'h01;
        next_whi = mem_rdata;
        next_state = mrs_pkg::S_WC;
      end
      mrs_pkg::S_WC: begin
        next_reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: waddr, wdata: {whi, mem_rdata}};
        next_wrote = 1'b1;
        next_wptr = wptr + 8'h02;
        next_waddr = waddr + 16'h0001;
        next_wcnt = wcnt - 8'h01;
        next_state = (wcnt == 8'h01) ? mrs_pkg::S_RESP : mrs_pkg::S_WA;
      end
      mrs_pkg::S_RESP: begin
        next_idx = 9'h000;
        next_tx_crc = mrs_pkg::CRC_INIT;
        next_have_word = 1'b0;
        next_state = (req.node == mrs_pkg::NODE_BCAST) ? mrs_pkg::S_RX : mrs_pkg::S_TX;
      end
      mrs_pkg::S_TX: begin
        if (!tx_valid || tx_ready) begin
          next_tx_valid = 1'b0;
          if (idx == nbody + 9'h002) begin
            next_state = mrs_pkg::S_RX;
          end else if (need_fetch) begin
            next_reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: rd_addr, wdata: 16'h0000};
            next_state = mrs_pkg::S_FETCH;
          end else begin
            next_tx_valid = 1'b1;
            next_idx = idx + 9'h001;
            if (idx < nbody) begin
              next_tx_data = body_byte;
              next_tx_crc = mrs_pkg::crc_byte(tx_crc, body_byte);
            end else begin
              next_tx_data = (idx == nbody) ? tx_crc[7:0] : tx_crc[15:8];
            end
            if (data_pos && !idx[0]) begin
              next_have_word = 1'b0;
            end
          end
        end
      end
      mrs_pkg::S_FETCH: begin
        next_state = mrs_pkg::S_FWAIT;
      end
      mrs_pkg::S_FWAIT: begin
        next_word = reg_rd_data;
        next_have_word = 1'b1;
        next_rd_addr = rd_addr + 16'h0001;
        next_state = mrs_pkg::S_TX;
      end
      default: begin
        next_state = mrs_pkg::S_RX;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= mrs_pkg::S_RX;
      kind <= mrs_pkg::K_EXC;
      exc <= 8'h00;
      wptr <= 8'h00;
      wcnt <= 8'h00;
      whi <= 8'h00;
      waddr <= 16'h0000;
      rd_addr <= 16'h0000;
      word <= 16'h0000;
      tx_crc <= mrs_pkg::CRC_INIT;
      idx <= 9'h000;
      have_word <= 1'b0;
      wrote <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      reg_req <= '0;
    end else if (ce) begin
      state <= next_state;
      kind <= next_kind;
      exc <= next_exc;
      wptr <= next_wptr;
      wcnt <= next_wcnt;
      whi <= next_whi;
      waddr <= next_waddr;
      rd_addr <= next_rd_addr;
      word <= next_word;
      tx_crc <= next_tx_crc;
      idx <= next_idx;
      have_word <= next_have_word;
      wrote <= next_wrote;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      reg_req <= next_reg_req;
    end
  end

  // ---- checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  own_node_a: assert property (tx_valid && idx == 9'h001 |-> tx_data == own_addr)
    else $error("response does not start with own node");
  exc_flag_a: assert property (tx_valid && kind == mrs_pkg::K_EXC && idx == 9'h002
    |-> tx_data == (req.func | mrs_pkg::EXC_FLAG)) else $error("exception flag missing");
  read_limit_a: assert property (ce && state == mrs_pkg::S_CHECK && frame_ok &&
    req.func == mrs_pkg::FC_READ && len == mrs_pkg::LEN_SHORT && req.count_a > mrs_pkg::MAX_READ_REGS
    |=> kind == mrs_pkg::K_EXC && exc == mrs_pkg::EXC_BAD_VALUE) else $error("no exception 2");
  bad_check_a: assert property (ce && state == mrs_pkg::S_CHECK && rx_crc != 16'h0000
    |=> state == mrs_pkg::S_RX) else $error("bad frame not dropped");
  over_write_a: assert property (ce && state == mrs_pkg::S_CHECK && frame_ok &&
    req.func == mrs_pkg::FC_WRITEN && req.count_a > mrs_pkg::MAX_WRITE_REGS
    |=> state == mrs_pkg::S_RX ##1 !tx_valid) else $error("oversize write answered");
  echo_after_a: assert property (tx_valid && kind == mrs_pkg::K_ECHO |-> wrote)
    else $error("echo before register write");
  single_data_a: assert property (ce && state == mrs_pkg::S_WR1
    |=> reg_req.wr_en && reg_req.wdata == {hdr_at(hdr, 9'h004), hdr_at(hdr, 9'h005)})
    else $error("write-single data wrong");
  bcast_quiet_a: assert property (state != mrs_pkg::S_RX && req.node == mrs_pkg::NODE_BCAST
    |-> !tx_valid) else $error("broadcast answered");
  crc_order_a: assert property (tx_valid && tx_ready && ce && idx == nbody + 9'h001
    |-> tx_data == tx_crc[7:0] ##1 tx_data == tx_crc[15:8]) else $error("check byte order");
  byte_count_a: assert property (tx_valid && kind == mrs_pkg::K_READ && idx == 9'h003
    |-> tx_data == {req.count_a[6:0], 1'b0}) else $error("read byte count wrong");

  read_resp_c: cover property (tx_valid && kind == mrs_pkg::K_READ && idx == nbody + 9'h002);
  exc_resp_c: cover property (tx_valid && kind == mrs_pkg::K_EXC && idx == 9'h003);
  multi_write_c: cover property (reg_req.wr_en ##3 reg_req.wr_en ##[1:4] state == mrs_pkg::S_TX);
  bcast_exec_c: cover property (reg_req.wr_en && req.node == mrs_pkg::NODE_BCAST);

endmodule : mrs_func_handler
`default_nettype wire

// ### tb/mrs_master_model.sv
// master-side model: request sender, response taker, register store
`timescale 1ns/1ps
`default_nettype none
module mrs_master_model (
  input wire logic core_clk,
  input wire logic ce,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire mrs_pkg::mrs_reg_req_t reg_req,
  output logic [15:0] reg_rd_data
);
  logic [15:0] regs [0:255];
  logic [7:0] rsp [$];
  logic [31:0] wlog [$];
  logic slow = 1'b0;
  time wr_t = 0;
  time tx_t = 0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    reg_rd_data = 16'h0000;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  // frame goes out with no gap, so only the closing silence ends it
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(negedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(negedge core_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send

  // slow mode takes a byte only every other cycle
  always @(negedge core_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  always @(posedge core_clk) begin
    if (tx_valid && tx_t == 0) begin
      tx_t = $time;
    end
    // a frozen handler neither hands over a byte nor finishes a register access
    if (ce && tx_valid && tx_ready) begin
      rsp.push_back(tx_data);
    end
    if (ce && reg_req.wr_en) begin
      regs[reg_req.addr[7:0]] <= reg_req.wdata;
      wlog.push_back({reg_req.addr, reg_req.wdata});
      wr_t = $time;
    end
    // read data holds one cycle only, then scrambles
    if (ce) begin
      reg_rd_data <= reg_req.rd_en ? regs[reg_req.addr[7:0]] : ~reg_rd_data;
    end
  end
endmodule : mrs_master_model
`default_nettype wire

// ### tb/mrs_func_handler_test.sv
// self-checking bench of the request handler
`timescale 1ns/1ps
`default_nettype none
module mrs_func_handler_test;
  localparam int SIL = 20;
  localparam logic [7:0] N = 8'h2A;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  // while set, ce drops every third cycle as the answer is awaited
  logic freeze = 1'b0;
  logic rx_valid, tx_valid, tx_ready, tx_two_stop;
  logic [7:0] rx_data, tx_data;
  logic [15:0] reg_rd_data;
  mrs_pkg::mrs_reg_req_t reg_req;
  int error_cnt = 0;
  int checks = 0;

  mrs_func_handler #(.SILENCE_CYCLES(SIL)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .own_addr(N),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tx_two_stop(tx_two_stop), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data)
  );
  mrs_master_model mdl (
    .core_clk(core_clk), .ce(ce), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .reg_req(reg_req), .reg_rd_data(reg_rd_data)
  );

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // empty exp means the frame must be dropped silently
  task automatic run(input logic [7:0] req[$], input logic [7:0] exp[$], input logic bad);
    logic [15:0] c;
    int n;
    mdl.rsp.delete();
    mdl.tx_t = 0;
    mdl.send(req, bad);
    if (exp.size() > 0) begin
      c = mdl.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    n = 0;
    while (n < 6000 && (exp.size() == 0 ? n < 3 * SIL : mdl.rsp.size() < exp.size())) begin
      @(negedge core_clk);
      ce <= !(freeze && n % 3 == 1);
      n++;
    end
    if (n == 6000) begin
      check(32'h0, 32'h1);
      give_verdict();
    end
    @(negedge core_clk);
    ce <= 1'b1;
    repeat (5) @(negedge core_clk);
    check(32'(mdl.rsp.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      if (i < mdl.rsp.size()) check({24'h0, mdl.rsp[i]}, {24'h0, exp[i]});
    end
  endtask : run

  task automatic t_read(input logic [15:0] cnt, input logic slow);
    logic [7:0] req[$];
    logic [7:0] exp[$];
    req = '{N, 8'h03, 8'h00, 8'h10, cnt[15:8], cnt[7:0]};
    exp = '{N, 8'h03, 8'(2 * cnt)};
    for (int i = 0; i < cnt; i++) begin
      exp.push_back(8'hA5);
      exp.push_back(8'(16 + i));
    end
    mdl.slow = slow;
    freeze = slow;
    run(req, exp, 1'b0);
    mdl.slow = 1'b0;
    freeze = 1'b0;
    $display("read of %0d registers done", cnt);
  endtask : t_read

  task automatic t_exc;
    logic [7:0] fc[3] = '{8'h03, 8'h05, 8'h03};
    logic [7:0] ct[3] = '{8'h7E, 8'h02, 8'h00};
    logic [7:0] ec[3] = '{8'h02, 8'h01, 8'h02};
    logic [7:0] req[$];
    logic [7:0] exp[$];
    for (int i = 0; i < 3; i++) begin
      req = '{N, fc[i], 8'h00, 8'h10, 8'h00, ct[i]};
      exp = '{N, fc[i] | 8'h80, ec[i]};
      run(req, exp, 1'b0);
    end
    $display("exception test done");
  endtask : t_exc

  task automatic t_write1;
    logic [7:0] req[$];
    mdl.wlog.delete();
    req = '{N, 8'h06, 8'h00, 8'h20, 8'hBE, 8'hEF};
    run(req, req, 1'b0);
    check(32'(mdl.wlog.size()), 32'h1);
    check(mdl.wlog[0], 32'h0020BEEF);
    check(32'(mdl.wr_t < mdl.tx_t), 32'h1);
    $display("single write test done");
  endtask : t_write1

  task automatic t_writen;
    logic [7:0] req[$];
    logic [7:0] exp[$];
    mdl.wlog.delete();
    req = '{N, 8'h10, 8'h00, 8'h40, 8'h00, 8'h03, 8'h06};
    for (int i = 0; i < 3; i++) begin
      req.push_back(8'hC0 + 8'(i));
      req.push_back(8'h0F);
    end
    exp = '{N, 8'h10, 8'h00, 8'h40, 8'h00, 8'h03};
    run(req, exp, 1'b0);
    check(32'(mdl.wlog.size()), 32'h3);
    for (int i = 0; i < 3; i++) begin
      check(mdl.wlog[i], {16'h0040 + 16'(i), 8'hC0 + 8'(i), 8'h0F});
    end
    $display("multiple write test done");
  endtask : t_writen

  task automatic t_rdwr;
    logic [7:0] req[$];
    logic [7:0] exp[$];
    mdl.wlog.delete();
    req = '{N, 8'h17, 8'h00, 8'h50, 8'h00, 8'h02, 8'h00, 8'h50, 8'h00, 8'h02, 8'h04,
            8'h12, 8'h34, 8'h56, 8'h78};
    exp = '{N, 8'h17, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78};
    run(req, exp, 1'b0);
    req = '{N, 8'h17, 8'h00, 8'h50, 8'h00, 8'h7E, 8'h00, 8'h60, 8'h00, 8'h01, 8'h02,
            8'hAB, 8'hCD};
    exp = '{N, 8'h97, 8'h02};
    run(req, exp, 1'b0);
    check(32'(mdl.wlog.size()), 32'h2);
    $display("read/write test done");
  endtask : t_rdwr

  task automatic t_quiet;
    logic [7:0] req[$];
    logic [7:0] exp[$];
    mdl.wlog.delete();
    req = '{8'h00, 8'h06, 8'h00, 8'h30, 8'h5A, 8'h5A};
    run(req, exp, 1'b0);
    check(32'(mdl.wlog.size()), 32'h1);
    req[0] = N;
    req[3] = 8'h31;
    run(req, exp, 1'b1);
    req[0] = N + 8'h01;
    run(req, exp, 1'b0);
    req = '{N, 8'h10, 8'h00, 8'h40, 8'h00, 8'h7C, 8'hF8};
    repeat (248) req.push_back(8'h33);
    run(req, exp, 1'b0);
    // the frame above overruns the buffer; this one fits but asks past the limit
    req = '{N, 8'h10, 8'h00, 8'h40, 8'h00, 8'h7C, 8'h02, 8'h33, 8'h33};
    run(req, exp, 1'b0);
    check(32'(mdl.wlog.size()), 32'h1);
    $display("dropped frame test done");
  endtask : t_quiet

  initial begin
    for (int i = 0; i < 256; i++) begin
      mdl.regs[i] = {8'hA5, 8'(i)};
    end
    repeat (20) @(negedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check({31'h0, tx_two_stop}, 32'h1);
    t_read(16'h0002, 1'b1);
    t_read(16'h007D, 1'b0);
    t_exc();
    t_write1();
    t_writen();
    t_rdwr();
    t_quiet();
    give_verdict();
  end
endmodule : mrs_func_handler_test
`default_nettype wire
